// [bench/cgpm_host_model.sv]
// Host model writing pattern and icon RAM and reading pattern RAM.
// Assumes inputs of the block are sampled on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module cgpm_host_model
    import cgpm_pkg::*;
(
    input  wire logic                   clock_i,
    output var cgpm_wr_t                wr_o,
    output logic      [CGPM_PAT_AW-1:0] rd_addr_o,
    input  wire logic [CGPM_DATA_W-1:0] rd_data_i
);
    initial begin
        wr_o = '0;
        rd_addr_o = '0;
    end
    // any word may be written; callers also write line eight.
    task automatic put(input logic pat, input logic [5:0] a,
                       input logic [7:0] d);
        @(negedge clock_i);
        wr_o = {pat, !pat, a, d};
        @(negedge clock_i);
        wr_o.pat_we = 1'b0;
        wr_o.icon_we = 1'b0;
        wr_o.data = ~d;
    endtask
    task automatic get(input logic [5:0] a, output logic [7:0] d);
        @(negedge clock_i);
        rd_addr_o = a;
        @(negedge clock_i);
        d = rd_data_i;
    endtask
endmodule
`default_nettype wire

// [bench/cgpm_map_bench.sv]
// Self-checking bench for the pattern and icon mapping block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module cgpm_map_bench;
    import cgpm_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] opt = 2'h3;
    logic ord = 1'b1;
    cgpm_wr_t wr;
    logic [5:0] rd_addr;
    cgpm_scan_t scan = '0;
    cgpm_row_t row;
    logic [7:0] prd, ird, d;
    logic [79:0] seg, exp_seg, exp_rev;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    always #10 clock_i = ~clock_i;
    cgpm_host_model u_host (.clock_i(clock_i), .wr_o(wr),
        .rd_addr_o(rd_addr), .rd_data_i(prd));
    cgpm_map uut (.clock_i(clock_i), .rst_i(rst_i),
        .pattern_size_opt_a_i(opt[0]), .pattern_size_opt_b_i(opt[1]),
        .segment_order_select_i(ord), .wr_i(wr), .rd_addr_i(rd_addr),
        .pat_rd_data_o(prd), .icon_rd_data_o(ird), .scan_i(scan),
        .row_o(row), .seg_icon_o(seg));
    task automatic chk(string n, logic [79:0] seen, logic [79:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            results();
        end
    end
    task automatic scan_cell(logic [7:0] c, logic [2:0] l, logic cur,
                             logic u, logic [4:0] dots);
        @(negedge clock_i);
        scan = {1'b1, c, l, cur};
        @(negedge clock_i);
        scan.valid = 1'b0;
        @(negedge clock_i);
        chk("row", {row.valid, row.user, row.dots}, {1'b1, u, dots});
    endtask
    task automatic test_pattern();
        for (int l = 0; l < 8; l++)
            u_host.put(1'b1, {3'h5, 3'(l)}, (l == 7) ? 8'h00 : 8'(8'he1 + 3*l));
        for (int l = 0; l < 7; l++) begin
            u_host.get({3'h5, 3'(l)}, d);
            chk("readback", d, 8'(8'he1 + 3*l));
            scan_cell(8'h0d, 3'(l), 1'b1, 1'b1, 5'(8'he1 + 3*l));
        end
        scan_cell(8'h05, 3'h7, 1'b1, 1'b1, 5'h1f);
        scan_cell(8'h05, 3'h7, 1'b0, 1'b1, 5'h00);
        u_host.put(1'b1, 6'h2f, 8'h04);
        scan_cell(8'h05, 3'h7, 1'b0, 1'b1, 5'h04);
        scan_cell(8'h45, 3'h1, 1'b0, 1'b0, 5'h00);
    endtask
    task automatic test_size();
        opt = 2'h0;
        repeat (4) @(negedge clock_i);
        u_host.put(1'b1, 6'h28, 8'h1f);
        u_host.get(6'h28, d);
        chk("dropped", d, 8'he1);
        u_host.put(1'b1, 6'h03, 8'h0a);
        u_host.get(6'h03, d);
        chk("small", d, 8'h0a);
        opt = 2'h3;
        repeat (4) @(negedge clock_i);
    endtask
    task automatic test_icon();
        logic [4:0] v;
        for (int n = 0; n < 16; n++) begin
            v = 5'(n * 7 + 3);
            u_host.put(1'b0, 6'(n), {3'h7, v});
            for (int b = 0; b < 5; b++) begin
                exp_seg[5*n+4-b] = v[b];
                exp_rev[75-5*n+b] = v[b];
            end
        end
        @(negedge clock_i);
        chk("icon_rd", ird, {3'h0, 5'(15 * 7 + 3)});
        chk("seg_fwd", seg, exp_seg);
        ord = 1'b0;
        repeat (5) @(negedge clock_i);
        chk("seg_rev", seg, exp_rev);
        u_host.put(1'b0, 6'h00, 8'h13);
        exp_rev[75 +: 5] = 5'h13;
        @(negedge clock_i);
        chk("seg_rev_wr", seg, exp_rev);
    endtask
    initial begin
        repeat (6) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clock_i);
        chk("seg_reset", seg, 80'h0);
        test_pattern();
        test_size();
        test_icon();
        results();
    end
endmodule
bind cgpm_map cgpm_map_monitor u_mon (.clock_i(clock_i), .rst_i(rst_i),
    .segment_order_select_i(segment_order_select_i), .wr_i(wr_i),
    .scan_i(scan_i), .row_o(row_o), .icon_rd_data_o(icon_rd_data_o),
    .seg_icon_o(seg_icon_o));
`default_nettype wire

// [bench/cgpm_map_monitor.sv]
// Checker for the mapping block, watching only its top-level ports.
// Assumes the bind in the bench top; one clock, async active-high reset.
`timescale 1ns/1ns
`default_nettype none
module cgpm_map_monitor
    import cgpm_pkg::*;
(
    input wire logic                   clock_i,
    input wire logic                   rst_i,
    input wire logic                   segment_order_select_i,
    input wire cgpm_wr_t               wr_i,
    input wire cgpm_scan_t             scan_i,
    input wire cgpm_row_t              row_o,
    input wire logic [CGPM_DATA_W-1:0] icon_rd_data_o,
    input wire logic [CGPM_SEGS-1:0]   seg_icon_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic [3:0] age_reg;
    logic       ord_reg;
    // Write data with its five dot bits in reversed order.
    wire  [4:0] wdata_rev = {wr_i.data[0], wr_i.data[1], wr_i.data[2],
                             wr_i.data[3], wr_i.data[4]};
    // Counts cycles since the order input last moved, saturating.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            age_reg <= 4'h0;
            ord_reg <= 1'b0;
        end else begin
            ord_reg <= segment_order_select_i;
            if (ord_reg != segment_order_select_i) age_reg <= 4'h0;
            else if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
        end
    end
    a_row_valid_lat: assert property (scan_i.valid |-> ##2 row_o.valid)
        else $error("row not valid two cycles after scan");
    a_row_idle: assert property (!scan_i.valid |-> ##2 !row_o.valid)
        else $error("row valid without scan");
    a_row_user_sel: assert property (scan_i.valid |-> ##2
        row_o.user == ($past(scan_i.code[7:4], 2) == 4'h0))
        else $error("user flag wrong");
    a_rom_code_dark: assert property (scan_i.valid &&
        scan_i.code[7:4] != 4'h0 |-> ##2 row_o.dots == 5'h00)
        else $error("non-user code gave dots");
    a_cursor_line_or: assert property (scan_i.valid &&
        scan_i.code[7:4] == 4'h0 && scan_i.line == 3'h7 && scan_i.cursor
        |-> ##2 row_o.dots == 5'h1f)
        else $error("cursor not merged on last line");
    a_icon_upper_zero: assert property (icon_rd_data_o[7:5] == 3'h0)
        else $error("icon upper bits not zero");
    a_icon_fwd_map: assert property (wr_i.icon_we && age_reg > 4'h4 &&
        ord_reg |-> ##2 seg_icon_o[5*$past(wr_i.addr[3:0], 2) +: 5] ==
        $past(wdata_rev, 2))
        else $error("forward icon map wrong");
    a_icon_rev_map: assert property (wr_i.icon_we && age_reg > 4'h4 &&
        !ord_reg |-> ##2 seg_icon_o[75-5*$past(wr_i.addr[3:0], 2) +: 5] ==
        $past(wr_i.data[4:0], 2))
        else $error("reversed icon map wrong");
    a_seg_quiet: assert property ($changed(seg_icon_o) |->
        $past(wr_i.icon_we, 2) || age_reg < 4'h6)
        else $error("segments changed without cause");
    c_cursor: cover property (scan_i.valid && scan_i.cursor);
    c_rom: cover property (scan_i.valid && scan_i.code[7:4] != 4'h0);
    c_icon: cover property (wr_i.icon_we && !ord_reg);
endmodule
`default_nettype wire

// [logic/cgpm_icon_ram.sv]
// Icon RAM of sixteen five-bit words, flattened to eighty segment bits.
// Assumes host writes on clock_i; upper data bits are not stored.
`timescale 1ns/1ns
`default_nettype none
module cgpm_icon_ram
    import cgpm_pkg::*;
(
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    input  wire logic                    we_i,
    input  wire logic [CGPM_ICON_AW-1:0] addr_i,
    input  wire logic [CGPM_DATA_W-1:0]  wdata_i,
    output logic      [CGPM_DATA_W-1:0]  rdata_o,
    output logic      [CGPM_SEGS-1:0]    bits_o
);

    logic [CGPM_DOTS-1:0] mem_reg [CGPM_ICON_WORDS];

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < CGPM_ICON_WORDS; i++) begin
                mem_reg[i] <= CGPM_ROW_RST;
            end
        end else if (we_i) begin
            mem_reg[addr_i] <= wdata_i[CGPM_DOTS-1:0];
        end
    end

    assign rdata_o = {3'h0, mem_reg[addr_i]};

    // Word n occupies bits 5n+4..5n of the flat vector.
    for (genvar n = 0; n < CGPM_ICON_WORDS; n++) begin : g_flat
        assign bits_o[CGPM_DOTS*n +: CGPM_DOTS] = mem_reg[n];
    end

endmodule
`default_nettype wire

// [logic/cgpm_map.sv]
// Pattern and icon mapping: turns a scanned character cell line into five
// dots from user pattern RAM and maps icon RAM onto eighty segments.
// Assumes scan and host requests are on clock_i; option straps are static.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Code bits 2..0 become pattern address bits 5..3, eight patterns.
// - Pattern address bits 2..0 are the line within the cell.
// - On line eight each dot is stored bit OR cursor.
// - Data bits 4..0 form dots, bit 4 leftmost, upper bits ignored.
// - User pattern used when code bits 7..4 are all zero.
// - Code bit 3 is ignored for user patterns.
// - Data one is a lit dot, zero unlit.
// - Pattern RAM size set by a two-bit fixed option.
// - Order select one: address n bit4..bit0 drive segments 5n+1..5n+5.
// - Order select zero: whole map reversed, address 0 bit 4 is segment 80.
// - Eight writable user patterns of five by eight dots.
// - Icon RAM holds eighty writable dots.
// - Pattern RAM beyond the option size ignores host writes.
module cgpm_map
    import cgpm_pkg::*;
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    input  wire logic                   pattern_size_opt_a_i,
    input  wire logic                   pattern_size_opt_b_i,
    input  wire logic                   segment_order_select_i,
    input  wire cgpm_wr_t               wr_i,
    input  wire logic [CGPM_PAT_AW-1:0] rd_addr_i,
    output logic      [CGPM_DATA_W-1:0] pat_rd_data_o,
    output logic      [CGPM_DATA_W-1:0] icon_rd_data_o,
    input  wire cgpm_scan_t             scan_i,
    output var cgpm_row_t               row_o,
    output logic      [CGPM_SEGS-1:0]   seg_icon_o
);

    // Straps pass two flip-flops before use.
    logic [1:0] opt_meta_reg;
    logic [1:0] opt_sync_reg;
    logic       order_meta_reg;
    logic       order_sync_reg;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            opt_meta_reg   <= 2'h0;
            opt_sync_reg   <= 2'h0;
            order_meta_reg <= 1'h0;
            order_sync_reg <= 1'h0;
        end else begin
            opt_meta_reg   <= {pattern_size_opt_b_i, pattern_size_opt_a_i};
            opt_sync_reg   <= opt_meta_reg;
            order_meta_reg <= segment_order_select_i;
            order_sync_reg <= order_meta_reg;
        end
    end

    // size option
    // Writable words are eight shifted left by the option; the display
    // side always reads the whole 64-word space.
    wire [CGPM_PAT_AW:0] limit_words =
        7'(CGPM_LINES * CGPM_LINES) >> (2'h3 - opt_sync_reg);
    wire pat_wr_ok = ({1'b0, wr_i.addr} < limit_words) ||
                     (opt_sync_reg == 2'h3);

    wire user_sel = scan_i.code[CGPM_USER_MSB:CGPM_USER_LSB] == 4'h0;

    wire [CGPM_PAT_AW-1:0] scan_addr =
        {scan_i.code[CGPM_SEL_MSB:CGPM_SEL_LSB], scan_i.line};

    logic [CGPM_DATA_W-1:0] pat_q;

    cgpm_pattern_ram #(
        .DEPTH (CGPM_LINES * CGPM_LINES)
    ) u_pat (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .we_i    (wr_i.pat_we && pat_wr_ok),
        .waddr_i (wr_i.addr),
        .wdata_i (wr_i.data),
        .raddr_i (scan_addr),
        .rdata_o (pat_q),
        .haddr_i (rd_addr_i),
        .hdata_o (pat_rd_data_o)
    );

    // Scan context delayed to line up with the registered RAM read.
    logic       scan_valid_reg;
    logic       scan_user_reg;
    logic       scan_last_reg;
    logic       scan_cursor_reg;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            scan_valid_reg  <= 1'h0;
            scan_user_reg   <= 1'h0;
            scan_last_reg   <= 1'h0;
            scan_cursor_reg <= 1'h0;
        end else begin
            scan_valid_reg  <= scan_i.valid;
            scan_user_reg   <= user_sel;
            scan_last_reg   <= scan_i.line == CGPM_CURSOR_LINE;
            scan_cursor_reg <= scan_i.cursor;
        end
    end

    wire [CGPM_DOTS-1:0] stored_dots = pat_q[CGPM_DOTS-1:0];
    wire [CGPM_DOTS-1:0] cursor_dots =
        {CGPM_DOTS{scan_last_reg && scan_cursor_reg}};
    wire [CGPM_DOTS-1:0] row_dots =
        scan_user_reg ? (stored_dots | cursor_dots) : CGPM_ROW_RST;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            row_o <= '0;
        end else begin
            row_o.valid <= scan_valid_reg;
            row_o.user  <= scan_user_reg;
            row_o.dots  <= row_dots;
        end
    end

    logic [CGPM_SEGS-1:0] icon_flat;

    cgpm_icon_ram u_icon (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .we_i    (wr_i.icon_we),
        .addr_i  (wr_i.addr[CGPM_ICON_AW-1:0]),
        .wdata_i (wr_i.data),
        .rdata_o (icon_rd_data_o),
        .bits_o  (icon_flat)
    );

    // Flat bit 5n+k holds word n, data bit k. Segment s is index s-1.
    logic [CGPM_SEGS-1:0] seg_fwd;
    logic [CGPM_SEGS-1:0] seg_rev;
    for (genvar n = 0; n < CGPM_ICON_WORDS; n++) begin : g_seg
        for (genvar k = 0; k < CGPM_DOTS; k++) begin : g_bit
            assign seg_fwd[CGPM_DOTS*n + (CGPM_DOTS-1-k)] =
                icon_flat[CGPM_DOTS*n + k];
            assign seg_rev[CGPM_SEGS-1 - (CGPM_DOTS*n + (CGPM_DOTS-1-k))] =
                icon_flat[CGPM_DOTS*n + k];
        end
    end

    wire [CGPM_SEGS-1:0] seg_sel = order_sync_reg ? seg_fwd : seg_rev;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            seg_icon_o <= '0;
        end else begin
            seg_icon_o <= seg_sel;
        end
    end

endmodule
`default_nettype wire

// [logic/cgpm_pattern_ram.sv]
// User pattern RAM: synchronous write, registered read port for display.
// Assumes host and scan logic share clock_i.
`timescale 1ns/1ns
`default_nettype none
module cgpm_pattern_ram
    import cgpm_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    input  wire logic                   we_i,
    input  wire logic [CGPM_PAT_AW-1:0] waddr_i,
    input  wire logic [CGPM_DATA_W-1:0] wdata_i,
    input  wire logic [CGPM_PAT_AW-1:0] raddr_i,
    output logic      [CGPM_DATA_W-1:0] rdata_o,
    input  wire logic [CGPM_PAT_AW-1:0] haddr_i,
    output logic      [CGPM_DATA_W-1:0] hdata_o
);

    // The address ports cannot reach beyond 64 words.
    if (DEPTH < 1 || DEPTH > (1 << CGPM_PAT_AW)) begin : g_bad_depth
        $error("cgpm_pattern_ram: DEPTH out of range");
    end

    logic [CGPM_DATA_W-1:0] mem [DEPTH];
    wire  r_hit = int'(raddr_i) < DEPTH;
    wire  h_hit = int'(haddr_i) < DEPTH;
    wire  w_hit = int'(waddr_i) < DEPTH;

    always_ff @(posedge clock_i) begin
        if (we_i && w_hit) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= CGPM_DATA_RST;
            hdata_o <= CGPM_DATA_RST;
        end else begin
            rdata_o <= r_hit ? mem[raddr_i] : CGPM_DATA_RST;
            hdata_o <= h_hit ? mem[haddr_i] : CGPM_DATA_RST;
        end
    end

endmodule
`default_nettype wire

// [logic/cgpm_pkg.sv]
// Shared constants and carrier types for the pattern and icon mapping block.
// Assumes a single clock domain; no software-visible registers.
package cgpm_pkg;

    localparam int CGPM_CODE_W      = 8;
    localparam int CGPM_DATA_W      = 8;
    localparam int CGPM_DOTS        = 5;
    localparam int CGPM_LINES       = 8;
    localparam int CGPM_PAT_AW      = 6;
    localparam int CGPM_ICON_AW     = 4;
    localparam int CGPM_ICON_WORDS  = 16;
    localparam int CGPM_SEGS        = 80;
    localparam int CGPM_OPT_W       = 2;

    // Field positions inside the character code.
    localparam int CGPM_SEL_LSB     = 0;
    localparam int CGPM_SEL_MSB     = 2;
    localparam int CGPM_USER_LSB    = 4;
    localparam int CGPM_USER_MSB    = 7;

    // The cursor is merged on the last line of the cell.
    localparam logic [2:0] CGPM_CURSOR_LINE = 3'h7;

    localparam logic [CGPM_DATA_W-1:0] CGPM_DATA_RST = 8'h00;
    localparam logic [CGPM_DOTS-1:0]   CGPM_ROW_RST  = 5'h00;

    // Host write port to either RAM.
    typedef struct packed {
        logic                   pat_we;
        logic                   icon_we;
        logic [CGPM_PAT_AW-1:0] addr;
        logic [CGPM_DATA_W-1:0] data;
    } cgpm_wr_t;

    // Display scan request for one character cell line.
    typedef struct packed {
        logic                   valid;
        logic [CGPM_CODE_W-1:0] code;
        logic [2:0]             line;
        logic                   cursor;
    } cgpm_scan_t;

    // Decoded row handed to the segment latch path.
    typedef struct packed {
        logic                 valid;
        logic                 user;
        logic [CGPM_DOTS-1:0] dots;
    } cgpm_row_t;

endpackage
